// ### verilog/rta_pkg.sv
// Constants shared by the alarm and calibration block of the clock unit.
// Assumes a 50 MHz system clock with a one-cycle 32.768 kHz enable.
package rta_pkg;

  // Register indices on the plain register port
  localparam logic [1:0] RTA_ADDR_CFGCAL = 2'h0;
  localparam logic [1:0] RTA_ADDR_ALCFG = 2'h1;
  localparam logic [1:0] RTA_ADDR_VAL_LO = 2'h2;
  localparam logic [1:0] RTA_ADDR_VAL_HI = 2'h3;

  // config_calibration_register fields
  localparam int RTA_CFG_TIMER_ON = 15;
  localparam int RTA_CFG_UNLOCK = 13;
  localparam int RTA_CFG_SYNC = 12;

  // alarm_configuration_register fields
  localparam int RTA_AL_ARM = 15;
  localparam int RTA_AL_CHIME = 14;
  localparam int RTA_AL_MASK_LO = 10;
  localparam int RTA_AL_PTR_LO = 8;

  // Implemented bits of the alarm value registers
  localparam logic [15:0] RTA_MD_BITS = 16'h1F3F;
  localparam logic [15:0] RTA_WH_BITS = 16'h073F;
  localparam logic [15:0] RTA_MS_BITS = 16'h7F7F;

  // Alarm window pointer codes
  localparam logic [1:0] RTA_PTR_MS = 2'h0;
  localparam logic [1:0] RTA_PTR_WH = 2'h1;
  localparam logic [1:0] RTA_PTR_MD = 2'h2;

  // Alarm interval codes
  localparam logic [3:0] RTA_M_HALF = 4'h0;
  localparam logic [3:0] RTA_M_SEC = 4'h1;
  localparam logic [3:0] RTA_M_10S = 4'h2;
  localparam logic [3:0] RTA_M_MIN = 4'h3;
  localparam logic [3:0] RTA_M_10M = 4'h4;
  localparam logic [3:0] RTA_M_HOUR = 4'h5;
  localparam logic [3:0] RTA_M_DAY = 4'h6;
  localparam logic [3:0] RTA_M_WEEK = 4'h7;
  localparam logic [3:0] RTA_M_MONTH = 4'h8;
  localparam logic [3:0] RTA_M_YEAR = 4'h9;

  // Time base: 32768 enable ticks per second
  localparam logic [16:0] RTA_PRE_TOP = 17'h0_7FFF;
  localparam logic [16:0] RTA_PRE_HALF = 17'h0_3FFF;
  localparam logic [16:0] RTA_SYNC_WIN = 17'h0_0020;
  localparam logic [5:0] RTA_SEC_LAST = 6'h3B;

  // Reset and wrap values
  localparam logic [15:0] RTA_REG_RST = 16'h0000;
  localparam logic [7:0] RTA_RPT_RST = 8'h00;
  localparam logic [7:0] RTA_RPT_WRAP = 8'hFF;

endpackage

// ### verilog/rta_match.sv
// Digit-masked compare of alarm values against the running time.
// Assumes both sides use the alarm register layouts; purely combinational.
`timescale 1ns/1ps
module rta_match (
  input wire logic [3:0] intervalSel,
  input wire logic [15:0] alarmMonthDay,
  input wire logic [15:0] alarmWeekdayHour,
  input wire logic [15:0] alarmMinuteSecond,
  input wire logic [15:0] timeMonthDay,
  input wire logic [15:0] timeWeekdayHour,
  input wire logic [15:0] timeMinuteSecond,
  output logic match
);
  import rta_pkg::*;

  logic eqSecOnes, eqSecTens, eqMinOnes, eqMinTens;
  logic eqHour, eqWday, eqDay, eqMonth;

  assign eqSecOnes = alarmMinuteSecond[3:0] == timeMinuteSecond[3:0];
  assign eqSecTens = alarmMinuteSecond[6:4] == timeMinuteSecond[6:4];
  assign eqMinOnes = alarmMinuteSecond[11:8] == timeMinuteSecond[11:8];
  assign eqMinTens = alarmMinuteSecond[14:12] == timeMinuteSecond[14:12];
  assign eqHour = alarmWeekdayHour[5:0] == timeWeekdayHour[5:0];
  assign eqWday = alarmWeekdayHour[10:8] == timeWeekdayHour[10:8];
  assign eqDay = alarmMonthDay[5:0] == timeMonthDay[5:0];
  assign eqMonth = alarmMonthDay[12:8] == timeMonthDay[12:8];

  always_comb begin
    unique case (intervalSel)
      RTA_M_HALF, RTA_M_SEC: match = 1'b1;
      RTA_M_10S: match = eqSecOnes;
      RTA_M_MIN: match = eqSecOnes & eqSecTens;
      RTA_M_10M: match = eqSecOnes & eqSecTens & eqMinOnes;
      RTA_M_HOUR: match = eqSecOnes & eqSecTens & eqMinOnes & eqMinTens;
      RTA_M_DAY: match = eqSecOnes & eqSecTens & eqMinOnes & eqMinTens &
                         eqHour;
      RTA_M_WEEK: match = eqSecOnes & eqSecTens & eqMinOnes & eqMinTens &
                          eqHour & eqWday;
      RTA_M_MONTH: match = eqSecOnes & eqSecTens & eqMinOnes & eqMinTens &
                           eqHour & eqDay;
      // Feb 29 matches only in leap years
      RTA_M_YEAR: match = eqSecOnes & eqSecTens & eqMinOnes & eqMinTens &
                          eqHour & eqDay & eqMonth;
      // Reserved codes never fire
      default: match = 1'b0;
    endcase
  end

endmodule

// ### verilog/rta_alarm_cal.sv
// Alarm compare, repeat counting and per-minute calibration of the clock unit.
// Assumes tbTick, the time inputs and the register port are all on clk.
`timescale 1ns/1ps
module rta_alarm_cal (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tbTick,
  input wire logic [15:0] timeMonthDay,
  input wire logic [15:0] timeWeekdayHour,
  input wire logic [15:0] timeMinuteSecond,
  input wire logic [1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWe,
  input wire logic regRe,
  output logic [15:0] regRdata,
  output logic alarmIrq,
  output logic alarmPulse,
  output logic secondPulse
);
  import rta_pkg::*;

  typedef struct packed {
    // Registered bus and event outputs
    logic [15:0] rdata;
    logic irq;
    logic apulse;
    logic secPulse;

    // Alarm value registers
    logic [15:0] monthDay;
    logic [15:0] weekdayHour;
    logic [15:0] minuteSecond;

    // Alarm configuration
    logic arm;
    logic chime;
    logic [3:0] intervalSel;
    logic [1:0] ptr;
    logic [7:0] repeatCount;

    // Calibration and time base
    logic [7:0] cal;
    logic timerOn;
    logic unlock;
    logic [16:0] pre;
    logic [5:0] secCnt;
  } rta_state_t;

  rta_state_t s_q;
  rta_state_t s_d;

  logic match;
  logic secTick;
  logic halfTick;
  logic alarmTick;
  logic alarmEvent;
  logic syncFlag;
  logic [16:0] calLoad;
  logic [15:0] winWord;
  logic winWritable;
  logic [15:0] cfgWord;
  logic [15:0] alcfgWord;
  logic hiAccess;
  logic minuteEnd;
  logic lastRepeat;

  rta_match u_match (
    .intervalSel(s_q.intervalSel),
    .alarmMonthDay(s_q.monthDay),
    .alarmWeekdayHour(s_q.weekdayHour),
    .alarmMinuteSecond(s_q.minuteSecond),
    .timeMonthDay(timeMonthDay),
    .timeWeekdayHour(timeWeekdayHour),
    .timeMinuteSecond(timeMinuteSecond),
    .match(match)
  );

  // The prescaler may start negative after a calibration load
  assign secTick = s_q.timerOn & tbTick &
                   ($signed(s_q.pre) >= $signed(RTA_PRE_TOP));
  assign halfTick = secTick |
                    (s_q.timerOn & tbTick & (s_q.pre == RTA_PRE_HALF));
  // Half-second code uses the half tick
  assign alarmTick = (s_q.intervalSel == RTA_M_HALF) ? halfTick : secTick;
  assign alarmEvent = s_q.arm & alarmTick & match;

  // Warns software that a second rollover is close
  // Config edits inside this window could race the alarm update
  assign syncFlag = s_q.timerOn &
                    ($signed(s_q.pre) >= $signed(RTA_PRE_TOP - RTA_SYNC_WIN));

  assign calLoad = {{7{s_q.cal[7]}}, s_q.cal, 2'b00};

  // Calibration loads at the end of the last second, so it trims second 0
  assign minuteEnd = secTick & (s_q.secCnt == RTA_SEC_LAST);

  // Any upper byte access moves the pointer down unless it is already 00, reads included
  assign hiAccess = (regWe | regRe) &
                    (regAddr == RTA_ADDR_VAL_HI);

  // Count already empty means final alarm, or a reload to FF when chime is set
  assign lastRepeat = s_q.repeatCount == RTA_RPT_RST;

  always_comb begin
    unique case (s_q.ptr)
      RTA_PTR_MS: begin
        winWord = s_q.minuteSecond;
        winWritable = 1'b1;
      end
      RTA_PTR_WH: begin
        winWord = s_q.weekdayHour;
        winWritable = s_q.unlock;
      end
      RTA_PTR_MD: begin
        winWord = s_q.monthDay;
        winWritable = s_q.unlock;
      end
      // Pointer code 11 has no register behind it
      default: begin
        winWord = RTA_REG_RST;
        winWritable = 1'b0;
      end
    endcase
  end

  always_comb begin
    cfgWord = RTA_REG_RST;
    cfgWord[RTA_CFG_TIMER_ON] = s_q.timerOn;
    cfgWord[RTA_CFG_UNLOCK] = s_q.unlock;
    cfgWord[RTA_CFG_SYNC] = syncFlag;
    cfgWord[7:0] = s_q.cal;
    alcfgWord = RTA_REG_RST;
    alcfgWord[RTA_AL_ARM] = s_q.arm;
    alcfgWord[RTA_AL_CHIME] = s_q.chime;
    alcfgWord[RTA_AL_MASK_LO +: 4] = s_q.intervalSel;
    alcfgWord[RTA_AL_PTR_LO +: 2] = s_q.ptr;
    alcfgWord[7:0] = s_q.repeatCount;
  end

  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.secPulse = 1'b0;
    s_d.rdata = RTA_REG_RST;

    // Time base and minute calibration
    // Timer off freezes the prescaler and the second count
    if (s_q.timerOn && tbTick) begin
      if (secTick) begin
        s_d.secPulse = 1'b1;
        if (minuteEnd) begin
          s_d.secCnt = '0;
          s_d.pre = calLoad;
        end else begin
          s_d.secCnt = s_q.secCnt + 6'h01;
          s_d.pre = '0;
        end
      end else begin
        s_d.pre = s_q.pre + 17'h0_0001;
      end
    end

    // Register reads
    if (regRe) begin
      unique case (regAddr)
        RTA_ADDR_CFGCAL: begin
          s_d.rdata = cfgWord;
        end
        RTA_ADDR_ALCFG: begin
          s_d.rdata = alcfgWord;
        end
        // Window reads return one byte, upper half zero
        RTA_ADDR_VAL_LO: begin
          s_d.rdata = {8'h00, winWord[7:0]};
        end
        RTA_ADDR_VAL_HI: begin
          s_d.rdata = {8'h00, winWord[15:8]};
        end
      endcase
    end

    // Register writes; window writes touch one byte at a time
    if (regWe) begin
      unique case (regAddr)
        RTA_ADDR_CFGCAL: begin
          s_d.timerOn = regWdata[RTA_CFG_TIMER_ON];
          s_d.unlock = regWdata[RTA_CFG_UNLOCK];
          s_d.cal = regWdata[7:0];
        end
        RTA_ADDR_ALCFG: begin
          s_d.arm = regWdata[RTA_AL_ARM];
          s_d.chime = regWdata[RTA_AL_CHIME];
          s_d.intervalSel = regWdata[RTA_AL_MASK_LO +: 4];
          s_d.ptr = regWdata[RTA_AL_PTR_LO +: 2];
          s_d.repeatCount = regWdata[7:0];
        end
        RTA_ADDR_VAL_LO, RTA_ADDR_VAL_HI: begin
          if (winWritable) begin
            unique case (s_q.ptr)
              RTA_PTR_MS: begin
                if (regAddr == RTA_ADDR_VAL_HI) begin
                  s_d.minuteSecond[15:8] = regWdata[7:0] & RTA_MS_BITS[15:8];
                end else begin
                  s_d.minuteSecond[7:0] = regWdata[7:0] & RTA_MS_BITS[7:0];
                end
              end
              RTA_PTR_WH: begin
                if (regAddr == RTA_ADDR_VAL_HI) begin
                  s_d.weekdayHour[15:8] = regWdata[7:0] & RTA_WH_BITS[15:8];
                end else begin
                  s_d.weekdayHour[7:0] = regWdata[7:0] & RTA_WH_BITS[7:0];
                end
              end
              RTA_PTR_MD: begin
                if (regAddr == RTA_ADDR_VAL_HI) begin
                  s_d.monthDay[15:8] = regWdata[7:0] & RTA_MD_BITS[15:8];
                end else begin
                  s_d.monthDay[7:0] = regWdata[7:0] & RTA_MD_BITS[7:0];
                end
              end
              default: begin
              end
            endcase
          end
        end
      endcase
    end

    if (hiAccess && s_q.ptr != RTA_PTR_MS) begin
      s_d.ptr = s_q.ptr - 2'h1;
    end

    // The alarm event is handled after the bus so hardware wins a tie
    if (alarmEvent) begin
      s_d.irq = 1'b1;
      s_d.apulse = ~s_q.apulse;
      if (!lastRepeat) begin
        s_d.repeatCount = s_q.repeatCount - 8'h01;
      end else if (s_q.chime) begin
        s_d.repeatCount = RTA_RPT_WRAP;
      end else begin
        s_d.arm = 1'b0;
      end
    end
  end

  // Whole state clears: timer off, alarm disarmed, pointer 00
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register
  assign regRdata = s_q.rdata;
  assign alarmIrq = s_q.irq;
  assign alarmPulse = s_q.apulse;
  assign secondPulse = s_q.secPulse;

endmodule

// ### verification/rta_alarm_cal_asserts.sv
// Port-level checker for the alarm and calibration block.
// Assumes tbTick and the register port are synchronous to clk.
`timescale 1ns/1ps
module rta_alarm_cal_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tbTick,
  input wire logic [1:0] regAddr,
  input wire logic regRe,
  input wire logic [15:0] regRdata,
  input wire logic alarmIrq,
  input wire logic alarmPulse,
  input wire logic secondPulse
);
  import rta_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_irq_one_cycle: assert property (alarmIrq |=> !alarmIrq [*8])
    else $error("alarm interrupt longer than one cycle");
  a_irq_after_tick: assert property (alarmIrq |-> $past(tbTick))
    else $error("alarm interrupt without a time-base tick");
  a_pulse_toggles: assert property (alarmIrq |-> $changed(alarmPulse))
    else $error("alarm pulse did not toggle on an alarm");
  a_pulse_holds: assert property (!alarmIrq |-> $stable(alarmPulse))
    else $error("alarm pulse moved without an alarm");
  a_rdata_idle: assert property (!$past(regRe) |-> regRdata == 16'h0000)
    else $error("read data not zero outside a read");
  a_window_byte: assert property ($past(regRe) && $past(regAddr[1])
    |-> regRdata[15:8] == 8'h00)
    else $error("window read drives the upper byte");
  a_sec_one_cycle: assert property (secondPulse |=> !secondPulse [*8])
    else $error("second pulse longer than one cycle");
  a_sec_after_tick: assert property (secondPulse |-> $past(tbTick))
    else $error("second pulse without a time-base tick");
endmodule

bind rta_alarm_cal rta_alarm_cal_asserts i_chk (
  .clk(clk),
  .rst_n(rst_n),
  .tbTick(tbTick),
  .regAddr(regAddr),
  .regRe(regRe),
  .regRdata(regRdata),
  .alarmIrq(alarmIrq),
  .alarmPulse(alarmPulse),
  .secondPulse(secondPulse)
);

// ### verification/tb_rtc_alarm_and_calibration.sv
// Self-checking bench for the alarm and calibration block.
// Assumes a tick every clock once the timer runs, so a second is 32768 clocks.
`timescale 1ns/1ps
module tb_rtc_alarm_and_calibration;
  import rta_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tbTick = 1'b0;
  logic [15:0] timeMonthDay = 16'h0000;
  logic [15:0] timeWeekdayHour = 16'h0000;
  logic [15:0] timeMinuteSecond = 16'h0000;
  logic [1:0] regAddr = 2'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWe = 1'b0;
  logic regRe = 1'b0;
  logic [15:0] regRdata;
  logic alarmIrq;
  logic alarmPulse;
  logic secondPulse;
  int mismatches = 0;
  int totalChecks = 0;
  int cycles = 0;
  logic [15:0] loExp [3] = '{16'h003F, 16'h003F, 16'h007F};
  logic [15:0] hiExp [3] = '{16'h001F, 16'h0007, 16'h007F};

  rta_alarm_cal i_dut (
    .clk(clk),
    .rst_n(rst_n),
    .tbTick(tbTick),
    .timeMonthDay(timeMonthDay),
    .timeWeekdayHour(timeWeekdayHour),
    .timeMinuteSecond(timeMinuteSecond),
    .regAddr(regAddr),
    .regWdata(regWdata),
    .regWe(regWe),
    .regRe(regRe),
    .regRdata(regRdata),
    .alarmIrq(alarmIrq),
    .alarmPulse(alarmPulse),
    .secondPulse(secondPulse)
  );

  always #10 clk = ~clk;

  task automatic endSim();
    if (mismatches == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    regWe <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWe <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, input logic [15:0] exp);
    @(posedge clk);
    regRe <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRe <= 1'b0;
    #1;
    chk(regRdata, exp);
  endtask

  task automatic waitIrq(input int n, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (alarmIrq === 1'b1) begin
        seen = 1'b1;
        break;
      end
    end
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask

  // Whole run needs about 82000 clocks
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      mismatches++;
      endSim();
    end
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(RTA_ADDR_CFGCAL, RTA_REG_RST);
    rd(RTA_ADDR_ALCFG, RTA_REG_RST);
    wr(RTA_ADDR_ALCFG, 16'h0200);
    wr(RTA_ADDR_VAL_LO, 16'h00FF);
    rd(RTA_ADDR_VAL_LO, 16'h0000);
    wr(RTA_ADDR_CFGCAL, 16'h20FC);
    rd(RTA_ADDR_CFGCAL, 16'h20FC);
    for (int i = 0; i < 3; i++) begin
      wr(RTA_ADDR_VAL_LO, 16'h00FF);
      wr(RTA_ADDR_VAL_HI, 16'h00FF);
    end
    rd(RTA_ADDR_ALCFG, 16'h0000);
    wr(RTA_ADDR_ALCFG, 16'h0200);
    for (int i = 0; i < 3; i++) begin
      rd(RTA_ADDR_VAL_LO, loExp[i]);
      rd(RTA_ADDR_VAL_HI, hiExp[i]);
    end
    wr(RTA_ADDR_ALCFG, 16'h0300);
    rd(RTA_ADDR_VAL_LO, 16'h0000);
    // Half-second alarm, one repeat: two alarms then disarm
    @(posedge clk);
    tbTick <= 1'b1;
    wr(RTA_ADDR_CFGCAL, 16'hA000);
    wr(RTA_ADDR_ALCFG, 16'h8001);
    waitIrq(17000, 1'b1);
    chk({15'h0000, alarmPulse}, 16'h0001);
    chk({15'h0000, secondPulse}, 16'h0000);
    waitIrq(17000, 1'b1);
    chk({15'h0000, alarmPulse}, 16'h0000);
    chk({15'h0000, secondPulse}, 16'h0001);
    rd(RTA_ADDR_ALCFG, 16'h0000);
    // Ten-second mode with unequal second ones must stay silent
    wr(RTA_ADDR_ALCFG, 16'h8801);
    waitIrq(34000, 1'b0);
    rd(RTA_ADDR_ALCFG, 16'h8801);
    wr(RTA_ADDR_ALCFG, 16'hC000);
    waitIrq(17000, 1'b1);
    rd(RTA_ADDR_ALCFG, 16'hC0FF);
    endSim();
  end
endmodule
